/* hdl/icache_data_ram.sv */
// Cache data array end: 512 x 32 storage, line decode, word select, sense
// and write paths. Assumes the partner end supplies phases and precharge.
//
// Function
// R01 - Store 512 words of 32 bits
// R02 - Six address bits pick one of 64 lines
// R03 - Word select picks word within line
// R04 - Partner holds one-hot word select through phase two
// R05 - Precharge bit lines during phase one
// R06 - Address latched at phase two rise
// R07 - Partner holds write enable through phase two
// R08 - Line selects gated by phase two
// R09 - Each line raises one row per half
// R10 - Read pulls bus low for stored zero
// R11 - Partner precharges bus high in phase one
// R12 - Write stores bus value into selected word
// R13 - Write drivers only when write and not phase one
// R14 - Sense path enabled on reads and writes
// R15 - Four word slices in each half
// R16 - Word select inputs are active high
// R17 - Predecode three groups of four
// R18 - Whole access fits one 50 ns cycle
// R19 - Partner lowers all selects on block miss
// R20 - No select: no drive, no store
`timescale 1ns/1ps
`include "icache_ram_consts.svh"

module icache_data_ram
	import icache_ram_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Link to tag unit and cache bus
	icache_bus_if.array_end link,
	// Test probe taps
	output logic [`LINE_COUNT-1:0] probe_word_lines,
	output logic probe_precharged
);

	// ============================================================
	// Storage
	logic [`WORD_BITS-1:0] left_half [0:`HALF_DEPTH-1]; // R01 R15
	logic [`WORD_BITS-1:0] right_half [0:`HALF_DEPTH-1]; // R01 R15

	// ============================================================
	// Declarations
	logic [`LINE_ADDR_BITS-1:0] addr_latch_reg;
	logic [`LINE_ADDR_BITS-1:0] addr_latch_next;
	logic [3:0] pre_low;
	logic [3:0] pre_mid;
	logic [3:0] pre_high;
	logic [`LINE_COUNT-1:0] line_select;
	logic [`LINE_COUNT-1:0] word_line;
	logic left_row_active;
	logic right_row_active;
	word_pick_t pick;
	logic slice_right;
	logic [`SLOT_BITS-1:0] slot;
	logic row_hit;
	logic sense_enable;
	logic [`WORD_BITS-1:0] sense_word;
	logic write_go;
	logic read_go;
	logic precharged_reg;
	logic precharged_next;
	logic [`WORD_BITS-1:0] pull_n_reg;
	logic [`WORD_BITS-1:0] pull_n_next;
	logic [`WORD_BITS-1:0] drive_level_reg;
	logic [`LINE_COUNT-1:0] probe_reg;

	// ============================================================
	// Address latch, flow-through while phase two is low
	always_comb begin
		if (link.clock_phase_two) begin
			addr_latch_next = addr_latch_reg; // R06
		end else begin
			addr_latch_next = link.line_address; // R06
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_latch_reg <= `LINE_ADDR_RESET;
		end else begin
			addr_latch_reg <= addr_latch_next;
		end
	end

	// ============================================================
	// Predecode and line decode
	always_comb begin
		pre_low = predecode_pair(addr_latch_reg[1:0]); // R17
		pre_mid = predecode_pair(addr_latch_reg[3:2]); // R17
		pre_high = predecode_pair(addr_latch_reg[5:4]); // R17
	end

	always_comb begin
		for (int i = 0; i < `LINE_COUNT; i++) begin
			line_select[i] = pre_low[i % 4] & pre_mid[(i / 4) % 4] & pre_high[i / 16]; // R02 R17
		end
	end

	// Word lines stay low until phase two
	always_comb begin
		if (link.clock_phase_two) begin
			word_line = line_select; // R08
		end else begin
			word_line = '0; // R08
		end
	end

	// Both half-plane rows rise together
	always_comb begin
		left_row_active = |word_line; // R09
		right_row_active = |word_line; // R09
	end

	// ============================================================
	// Word select
	always_comb begin
		pick = word_pick(link.word_select_onehot); // R03 R16
		slice_right = pick.index[2]; // R15
		slot = {addr_latch_reg, pick.index[1:0]}; // R15
		row_hit = pick.valid & left_row_active & right_row_active; // R20
	end

	// ============================================================
	// Sense path, on for reads and writes alike
	always_comb begin
		sense_enable = row_hit; // R14
		if (slice_right) begin
			sense_word = right_half[slot];
		end else begin
			sense_word = left_half[slot];
		end
	end

	// ============================================================
	// Access qualifiers
	always_comb begin
		write_go = row_hit & link.write_enable & link.clock_phase_one_inverted; // R13
		read_go = sense_enable & ~link.write_enable & precharged_reg; // R05 R10
	end

	// ============================================================
	// Bit-line precharge state
	always_comb begin
		if (link.clock_phase_one) begin
			precharged_next = 1'b1; // R05
		end else if (!link.clock_phase_two) begin
			precharged_next = 1'b0; // R05
		end else begin
			precharged_next = precharged_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			precharged_reg <= 1'b0;
		end else begin
			precharged_reg <= precharged_next;
		end
	end

	// ============================================================
	// Write drivers
	always_ff @(posedge clk_sys) begin
		if (write_go && !slice_right) begin
			left_half[slot] <= link.cache_data; // R12
		end
	end

	always_ff @(posedge clk_sys) begin
		if (write_go && slice_right) begin
			right_half[slot] <= link.cache_data; // R12
		end
	end

	// ============================================================
	// Sense amplifier bus pull-down
	always_comb begin
		if (read_go) begin
			pull_n_next = sense_word; // R10
		end else begin
			pull_n_next = `BUS_RELEASED; // R20
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pull_n_reg <= `BUS_RELEASED;
		end else begin
			pull_n_reg <= pull_n_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			drive_level_reg <= `BUS_LOW;
		end else begin
			drive_level_reg <= `BUS_LOW;
		end
	end

	// ============================================================
	// Probe taps
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			probe_reg <= '0;
		end else begin
			probe_reg <= word_line;
		end
	end

	// ============================================================
	// Outputs
	assign link.array_data_oe_n = pull_n_reg;
	assign link.array_data_out = drive_level_reg;
	assign probe_word_lines = probe_reg;
	assign probe_precharged = precharged_reg;

endmodule : icache_data_ram

/* hdl/icache_ram_consts.svh */
// Constants for the instruction cache data array and its partner end.
// Assumes inclusion by bare name from the package and the modules.
`ifndef ICACHE_RAM_CONSTS_SVH
`define ICACHE_RAM_CONSTS_SVH

// ============================================================
// Array geometry
`define WORD_BITS 32
`define LINE_ADDR_BITS 6
`define LINE_COUNT 64
`define WORDS_PER_LINE 8
`define WORDS_PER_HALF 4
`define HALF_DEPTH 256
`define SLOT_BITS 8
`define ROW_CELLS 128

// ============================================================
// Timing
`define CLK_PERIOD_NS 8
`define ACCESS_CYCLE_NS 50
`define ACCESS_CYCLE_CLKS (`ACCESS_CYCLE_NS / `CLK_PERIOD_NS)
`define PHASE_CLKS (`ACCESS_CYCLE_CLKS / 2)
`define PHASE_CNT_BITS 2

// ============================================================
// Reset values
`define LINE_ADDR_RESET 6'h00
`define WORD_SELECT_RESET 8'h00
`define BUS_RELEASED 32'hffffffff
`define BUS_LOW 32'h00000000

`endif

/* hdl/icache_ram_pkg.sv */
// Types and shared decode functions for the cache data array.
// Assumes icache_ram_consts.svh on the include path.
`include "icache_ram_consts.svh"

package icache_ram_pkg;

	// ============================================================
	// Types
	typedef struct packed {
		logic valid;
		logic [2:0] index;
	} word_pick_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PHASE_ONE = 2'b01,
		ST_PHASE_TWO = 2'b10
	} access_state_t;

	// ============================================================
	// Functions
	function automatic logic [3:0] predecode_pair(input logic [1:0] bits);
		predecode_pair = 4'h1 << bits;
	endfunction : predecode_pair

	function automatic word_pick_t word_pick(input logic [7:0] sel);
		word_pick_t pick;
		pick = '{valid: 1'b0, index: 3'h0};
		for (int i = 0; i < 8; i++) begin
			if (sel == (8'h01 << i)) begin
				pick.valid = 1'b1;
				pick.index = i[2:0];
			end
		end
		return pick;
	endfunction : word_pick

endpackage : icache_ram_pkg

/* hdl/icache_bus_if.sv */
// Link between the cache data array and the tag unit / bus interface end.
// Assumes both ends run on clk_sys; the shared bus is resolved here.
`timescale 1ns/1ps
`include "icache_ram_consts.svh"

interface icache_bus_if;
	// ============================================================
	// Clock phases
	logic clock_phase_one;
	logic clock_phase_one_inverted;
	logic clock_phase_two;
	// ============================================================
	// Addressing and control
	logic [`LINE_ADDR_BITS-1:0] line_address;
	logic [`WORDS_PER_LINE-1:0] word_select_onehot;
	logic write_enable;
	// ============================================================
	// Shared cache bus, open drain on the array side
	logic [`WORD_BITS-1:0] array_data_out;
	logic [`WORD_BITS-1:0] array_data_oe_n;
	logic [`WORD_BITS-1:0] host_data_out;
	logic [`WORD_BITS-1:0] host_data_oe_n;
	logic [`WORD_BITS-1:0] cache_data;

	// Released bits float high on the precharged bus
	assign cache_data = (host_data_out | host_data_oe_n) & (array_data_out | array_data_oe_n);

	modport array_end (
		input clock_phase_one, clock_phase_one_inverted, clock_phase_two,
		input line_address, word_select_onehot, write_enable, cache_data,
		output array_data_out, array_data_oe_n
	);

	modport host_end (
		output clock_phase_one, clock_phase_one_inverted, clock_phase_two,
		output line_address, word_select_onehot, write_enable,
		output host_data_out, host_data_oe_n,
		input cache_data
	);
endinterface : icache_bus_if

/* hdl/icache_ram_host.sv */
// Partner end: phase generator, tag-unit address/select drive and
// instruction-holding-stage bus precharge, write data and read capture.
`timescale 1ns/1ps
`include "icache_ram_consts.svh"

module icache_ram_host
	import icache_ram_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Link to the data array
	icache_bus_if.host_end link,
	// Request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_miss,
	input wire logic [`LINE_ADDR_BITS-1:0] req_line,
	input wire logic [2:0] req_word,
	input wire logic [`WORD_BITS-1:0] req_wdata,
	output logic req_ready,
	// Answer
	output logic rsp_valid,
	output logic [`WORD_BITS-1:0] rsp_data
);

	// ============================================================
	// Declarations
	access_state_t state_reg;
	logic [`PHASE_CNT_BITS-1:0] cnt_reg;
	logic last_clk;
	logic ph1_next;
	logic ph1_reg;
	logic ph1_inv_reg;
	logic ph2_reg;
	logic write_reg;
	logic [`LINE_ADDR_BITS-1:0] line_reg;
	logic [`WORDS_PER_LINE-1:0] sel_reg;
	logic [`WORD_BITS-1:0] out_reg;
	logic [`WORD_BITS-1:0] oe_n_reg;
	logic ready_reg;
	logic rsp_valid_reg;
	logic [`WORD_BITS-1:0] rsp_data_reg;

	assign last_clk = (cnt_reg == 2'(`PHASE_CLKS - 1));

	// ============================================================
	// Phase sequencer, two 24 ns phases plus an idle clock, one access per 56 ns at best
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					cnt_reg <= '0;
					if (req_valid) begin
						state_reg <= ST_PHASE_ONE;
					end
				end
				ST_PHASE_ONE: begin
					cnt_reg <= last_clk ? '0 : cnt_reg + 2'h1;
					if (last_clk) begin
						state_reg <= ST_PHASE_TWO;
					end
				end
				ST_PHASE_TWO: begin
					cnt_reg <= last_clk ? '0 : cnt_reg + 2'h1;
					if (last_clk) begin
						state_reg <= ST_IDLE; // R18
					end
				end
			endcase
		end
	end

	// Phase levels, never high together
	assign ph1_next = (state_reg == ST_IDLE && req_valid) ||
		(state_reg == ST_PHASE_ONE && !last_clk);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ph1_reg <= 1'b0;
			ph1_inv_reg <= 1'b1;
			ph2_reg <= 1'b0;
		end else begin
			ph1_reg <= ph1_next;
			ph1_inv_reg <= ~ph1_next;
			ph2_reg <= (state_reg == ST_PHASE_ONE && last_clk) ||
				(state_reg == ST_PHASE_TWO && !last_clk);
		end
	end

	// ============================================================
	// Request capture, held for the whole access
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			write_reg <= 1'b0;
			line_reg <= `LINE_ADDR_RESET;
			sel_reg <= `WORD_SELECT_RESET;
		end else if (state_reg == ST_IDLE && req_valid) begin
			write_reg <= req_write; // R07
			line_reg <= req_line; // R06
			sel_reg <= req_miss ? `WORD_SELECT_RESET : 8'(8'h01 << req_word); // R04 R19
		end
	end

	// ============================================================
	// Bus drive: precharge on reads, data on writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_reg <= `BUS_RELEASED;
			oe_n_reg <= `BUS_RELEASED;
		end else if (state_reg == ST_IDLE && req_valid) begin
			out_reg <= req_write ? req_wdata : `BUS_RELEASED; // R11
			oe_n_reg <= `BUS_LOW;
		end else if (state_reg == ST_PHASE_ONE && last_clk && !write_reg) begin
			oe_n_reg <= `BUS_RELEASED; // R11
		end else if (state_reg == ST_PHASE_TWO && last_clk) begin
			out_reg <= `BUS_RELEASED;
			oe_n_reg <= `BUS_RELEASED;
		end
	end

	// ============================================================
	// Handshake and read capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ready_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= `BUS_LOW;
		end else begin
			ready_reg <= (state_reg == ST_IDLE && !req_valid) ||
				(state_reg == ST_PHASE_TWO && last_clk);
			rsp_valid_reg <= state_reg == ST_PHASE_TWO && last_clk && !write_reg;
			if (state_reg == ST_PHASE_TWO && last_clk && !write_reg) begin
				rsp_data_reg <= link.cache_data;
			end
		end
	end

	// ============================================================
	// Outputs
	assign link.clock_phase_one = ph1_reg;
	assign link.clock_phase_one_inverted = ph1_inv_reg;
	assign link.clock_phase_two = ph2_reg;
	assign link.line_address = line_reg;
	assign link.word_select_onehot = sel_reg;
	assign link.write_enable = write_reg;
	assign link.host_data_out = out_reg;
	assign link.host_data_oe_n = oe_n_reg;
	assign req_ready = ready_reg;
	assign rsp_valid = rsp_valid_reg;
	assign rsp_data = rsp_data_reg;

endmodule : icache_ram_host

/* bench/icache_link_props.sv */
// Checker for the link between the cache data array and its host end.
// Assumes instantiation beside icache_bus_if, signals passed by name.
`timescale 1ns/1ps

module icache_link_props (
	// Clock and reset
	input logic clk_sys,
	input logic rst_n,
	// Phases
	input logic clock_phase_one,
	input logic clock_phase_one_inverted,
	input logic clock_phase_two,
	// Control
	input logic [5:0] line_address,
	input logic [7:0] word_select_onehot,
	input logic write_enable,
	// Bus drive
	input logic [31:0] array_data_oe_n,
	input logic [31:0] host_data_out,
	input logic [31:0] host_data_oe_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ============================================================
	// Phase sequences
	sequence s_ph1_run;
		clock_phase_one [*3] ##1 (!clock_phase_one && clock_phase_two);
	endsequence
	sequence s_ph2_run;
		clock_phase_two [*3] ##1 !clock_phase_two;
	endsequence

	// ============================================================
	// Assertions
	chk_ph1_length: assert property ($rose(clock_phase_one) |-> s_ph1_run)
		else $error("phase one length wrong");
	chk_ph2_length: assert property ($rose(clock_phase_two) |-> s_ph2_run)
		else $error("phase two length wrong");
	chk_no_overlap: assert property (!(clock_phase_one && clock_phase_two))
		else $error("phases overlap");
	chk_inv_phase: assert property (clock_phase_one_inverted != clock_phase_one)
		else $error("inverted phase wrong");
	chk_quiet_ph1: assert property ($rose(clock_phase_one) |=> (&array_data_oe_n) [*3])
		else $error("array drives in phase one");
	chk_write_quiet: assert property (clock_phase_two && write_enable |=> &array_data_oe_n)
		else $error("array drives on write");
	chk_idle_select: assert property (clock_phase_two && word_select_onehot == 8'h00
		|=> &array_data_oe_n)
		else $error("array drives without select");
	chk_sel_onehot: assert property (clock_phase_two |-> $onehot0(word_select_onehot))
		else $error("select not one hot");
	chk_addr_hold: assert property (clock_phase_two && !$rose(clock_phase_two)
		|-> $stable(line_address) && $stable(write_enable))
		else $error("address or write moved");
	chk_host_precharge: assert property (clock_phase_one && $past(clock_phase_one)
		&& !write_enable |-> host_data_oe_n == 32'h00000000
		&& host_data_out == 32'hffffffff)
		else $error("bus not precharged");
	chk_host_wdata: assert property (clock_phase_two && write_enable
		|-> host_data_oe_n == 32'h00000000)
		else $error("write data not driven");
endmodule : icache_link_props

/* bench/icache_data_ram_test.sv */
// Self-checking bench: data array and host end joined by icache_bus_if.
// Assumes the host request port walks each access through both phases.
`timescale 1ns/1ps

module icache_data_ram_test;
	import icache_ram_pkg::*;
	// ============================================================
	// Signals
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_miss = 1'b0;
	logic [5:0] req_line = 6'h00;
	logic [2:0] req_word = 3'h0;
	logic [31:0] req_wdata = 32'h00000000;
	logic req_ready;
	logic rsp_valid;
	logic [31:0] rsp_data;
	logic [63:0] probe_word_lines;
	logic probe_precharged;
	int num_errors = 0;
	int comparisons = 0;

	always #4 clk_sys = ~clk_sys;

	// ============================================================
	// Instances
	icache_bus_if link ();
	icache_data_ram u_icache_data_ram (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.array_end),
		.probe_word_lines(probe_word_lines), .probe_precharged(probe_precharged));
	icache_ram_host u_icache_ram_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.host_end),
		.req_valid(req_valid), .req_write(req_write), .req_miss(req_miss), .req_line(req_line),
		.req_word(req_word), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	icache_link_props u_icache_link_props (.clk_sys(clk_sys), .rst_n(rst_n),
		.clock_phase_one(link.clock_phase_one),
		.clock_phase_one_inverted(link.clock_phase_one_inverted),
		.clock_phase_two(link.clock_phase_two), .line_address(link.line_address),
		.word_select_onehot(link.word_select_onehot), .write_enable(link.write_enable),
		.array_data_oe_n(link.array_data_oe_n), .host_data_out(link.host_data_out),
		.host_data_oe_n(link.host_data_oe_n));

	// ============================================================
	// Helpers
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	task automatic count_check(input logic bad, input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (bad) begin
			num_errors++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : count_check

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		count_check(got !== exp, {32'h00000000, got}, {32'h00000000, exp});
	endtask : check_word

	task automatic check_lines(input logic [63:0] got, input logic [63:0] exp);
		count_check(got !== exp, got, exp);
	endtask : check_lines

	task automatic check_flag(input logic got, input logic exp);
		count_check(got !== exp, {63'h0, got}, {63'h0, exp});
	endtask : check_flag

	function automatic logic pick(input int w);
		return (w == 0) ? req_ready : (w == 1) ? rsp_valid : link.clock_phase_two;
	endfunction : pick

	task automatic wait_high(input int w);
		int n;
		n = 0;
		while (pick(w) !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		if (pick(w) !== 1'b1) begin
			num_errors++;
			give_verdict();
		end
	endtask : wait_high

	function automatic logic [31:0] pat(input logic [5:0] l, input logic [2:0] w);
		return 32'h9e3779b9 * {23'h000000, l, w} ^ 32'h5a5a0ff0;
	endfunction : pat

	task automatic access(input logic wr, input logic miss, input logic [5:0] l,
		input logic [2:0] w, input logic [31:0] wd, output logic [31:0] rd);
		@(negedge clk_sys);
		wait_high(0);
		req_valid = 1'b1;
		req_write = wr;
		req_miss = miss;
		req_line = l;
		req_word = w;
		req_wdata = wd;
		@(negedge clk_sys);
		req_valid = 1'b0;
		rd = 32'h00000000;
		if (!wr) begin
			if (!miss) begin
				wait_high(2);
				@(negedge clk_sys);
				check_lines(probe_word_lines, 64'h1 << l);
				check_flag(probe_precharged, 1'b1);
			end
			wait_high(1);
			rd = rsp_data;
			@(negedge clk_sys);
			check_flag(probe_precharged, 1'b0);
		end
	endtask : access

	// ============================================================
	// Scenarios
	task automatic t_fill_all();
		logic [31:0] rd;
		for (int i = 0; i < 512; i++) begin
			access(1'b1, 1'b0, i[8:3], i[2:0], pat(i[8:3], i[2:0]), rd);
		end
		for (int i = 0; i < 512; i++) begin
			access(1'b0, 1'b0, i[8:3], i[2:0], 32'h00000000, rd);
			check_word(rd, pat(i[8:3], i[2:0]));
		end
		$display("test fill_all done");
	endtask : t_fill_all

	task automatic t_extremes();
		logic [31:0] rd;
		access(1'b1, 1'b0, 6'h00, 3'h0, 32'h00000000, rd);
		access(1'b1, 1'b0, 6'h3f, 3'h7, 32'hffffffff, rd);
		access(1'b0, 1'b0, 6'h00, 3'h0, 32'h00000000, rd);
		check_word(rd, 32'h00000000);
		access(1'b0, 1'b0, 6'h3f, 3'h7, 32'h00000000, rd);
		check_word(rd, 32'hffffffff);
		access(1'b0, 1'b0, 6'h00, 3'h1, 32'h00000000, rd);
		check_word(rd, pat(6'h00, 3'h1));
		access(1'b0, 1'b0, 6'h3f, 3'h6, 32'h00000000, rd);
		check_word(rd, pat(6'h3f, 3'h6));
		$display("test extremes done");
	endtask : t_extremes

	task automatic t_miss();
		logic [31:0] rd;
		access(1'b1, 1'b1, 6'h09, 3'h2, ~pat(6'h09, 3'h2), rd);
		access(1'b0, 1'b0, 6'h09, 3'h2, 32'h00000000, rd);
		check_word(rd, pat(6'h09, 3'h2));
		access(1'b0, 1'b1, 6'h09, 3'h2, 32'h00000000, rd);
		check_word(rd, 32'hffffffff);
		$display("test miss done");
	endtask : t_miss

	initial begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		t_fill_all();
		t_extremes();
		t_miss();
		give_verdict();
	end
endmodule : icache_data_ram_test
